/* File: include/irq_pkg.sv */
package irq_pkg;

   // --------------------------------------------------------------------
   // register word indices (byte address = 4 * index)
   // --------------------------------------------------------------------
   localparam logic [5:0] IDX_FLAGS = 6'h06;
   localparam logic [5:0] IDX_ENABLES = 6'h07;
   localparam logic [5:0] IDX_EVT_STATUS = 6'h08;
   localparam logic [5:0] IDX_EVT_CLEAR = 6'h09;
   localparam logic [5:0] IDX_EVT_ENABLE = 6'h0A;

   // --------------------------------------------------------------------
   // field positions
   // --------------------------------------------------------------------
   localparam int REG_W = 8;
   localparam int BIT_GLOBAL = 7;
   localparam int BIT_TIMER = 4;
   localparam int BIT_SERIAL = 3;
   localparam int BIT_CONVERTER = 2;
   localparam int BIT_PIN1 = 1;
   localparam int BIT_PIN0 = 0;
   localparam int N_PINS = 2;
   localparam int EVT_W = 6;
   localparam int EVT_BAD_ACCESS = 5;

   // --------------------------------------------------------------------
   // implemented-bit masks and reset values
   // --------------------------------------------------------------------
   localparam logic [7:0] FLAGS_MASK = 8'h1F;
   localparam logic [7:0] ENABLES_MASK = 8'h9F;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] ENABLES_RESET = 8'h00;
   localparam logic [5:0] EVT_RESET = 6'h00;

   // --------------------------------------------------------------------
   // shared vector of the core
   // --------------------------------------------------------------------
   localparam int PC_W = 13;
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;

endpackage

/* File: include/pin_event_if.sv */
`timescale 1ns/1ns
`default_nettype none

// carries raw pin levels in, filtered levels and rise pulses out
interface pin_event_if #(
   parameter int N = 2
);
   logic [N-1:0] raw;
   logic [N-1:0] level;
   logic [N-1:0] rise;

   modport sync (
      input raw,
      output level,
      output rise
   );

   modport user (
      output raw,
      input level,
      input rise
   );
endinterface // pin_event_if

`default_nettype wire

/* File: design/pin_event_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module pin_event_sync #(
   parameter int N = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pin side and filtered side
   pin_event_if.sync pins
);

   // --------------------------------------------------------------------
   // elaboration check
   // --------------------------------------------------------------------
   if (N < 1) begin : g_bad_n
      $error("pin_event_sync: N must be at least 1");
   end

   logic [N-1:0] sync1_reg;
   logic [N-1:0] sync2_reg;
   logic [N-1:0] sync3_reg;
   logic [N-1:0] level_reg;
   logic [N-1:0] rise_reg;
   logic [N-1:0] agree;

   // three-stage synchroniser, first stage read only by the second
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= pins.raw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // a change counts once stages two and three agree
   assign agree = ~(sync2_reg ^ sync3_reg);

   // accepted level and one-cycle rise pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         level_reg <= '0;
         rise_reg <= '0;
      end else begin
         level_reg <= (agree & sync3_reg) | (~agree & level_reg);
         rise_reg <= agree & sync3_reg & ~level_reg;
      end
   end

   assign pins.level = level_reg;
   assign pins.rise = rise_reg;

endmodule // pin_event_sync

`default_nettype wire

/* File: design/irq_enable_flag_unit.sv */
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module irq_enable_flag_unit
   import irq_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // peripheral events, one-cycle pulses on clk
   input wire logic timer_event,
   input wire logic serial_event,
   input wire logic converter_event,
   // external pins, asynchronous
   input wire logic port_b_line1,
   input wire logic port_b_line0,
   // to the cpu core
   output logic core_irq_request,
   output logic [PC_W-1:0] core_irq_vector,
   // bus-side interrupt
   output logic irq
);

   // --------------------------------------------------------------------
   // elaboration checks
   // --------------------------------------------------------------------
   if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
      $error("irq_enable_flag_unit: ADDR_W must lie in 6..32");
   end

   // --------------------------------------------------------------------
   // declarations
   // --------------------------------------------------------------------
   logic [7:0] interrupt_flags_reg;
   logic [7:0] interrupt_flags_next;
   logic [7:0] interrupt_enables_reg;
   logic [7:0] interrupt_enables_next;
   logic [EVT_W-1:0] evt_status_reg;
   logic [EVT_W-1:0] evt_status_next;
   logic [EVT_W-1:0] evt_enable_reg;
   logic [EVT_W-1:0] evt_clear;
   logic [EVT_W-1:0] evt_set;
   logic [7:0] flag_set;
   logic [31:0] readdata_reg;
   logic ack_reg;
   logic core_irq_reg;
   logic irq_reg;
   logic request;
   logic wr_take;
   logic rd_take;
   logic low_lane;
   logic [5:0] index;
   logic global_irq_enable;
   logic [7:0] source_enables;
   logic [7:0] pending;

   // filtered pin edges come back over the carrier
   pin_event_if #(.N(N_PINS)) pin_bus ();

   // --------------------------------------------------------------------
   // helper functions
   // --------------------------------------------------------------------

   // word index of a byte address
   function automatic logic [5:0] word_index(input logic [ADDR_W-1:0] a);
      logic [31:0] wide;
      wide = 32'h0000_0000;
      wide[ADDR_W-1:0] = a;
      return wide[7:2];
   endfunction

   // true when an index names a register of this block
   function automatic logic is_mapped(input logic [5:0] idx, input logic [ADDR_W-1:0] a);
      logic [31:0] wide;
      logic upper_zero;
      wide = 32'h0000_0000;
      wide[ADDR_W-1:0] = a;
      upper_zero = (wide[31:8] == 24'h00_0000);
      return upper_zero && (idx == IDX_FLAGS || idx == IDX_ENABLES || idx == IDX_EVT_STATUS ||
                            idx == IDX_EVT_CLEAR || idx == IDX_EVT_ENABLE);
   endfunction

   // --------------------------------------------------------------------
   // pin edge detection
   // --------------------------------------------------------------------

   // external lines into the synchroniser
   assign pin_bus.raw = {port_b_line1, port_b_line0};

   pin_event_sync #(
      .N(N_PINS)
   ) u_pin_sync (
      .clk(clk),
      .rst(rst),
      .pins(pin_bus.sync)
   );

   // --------------------------------------------------------------------
   // bus handshake
   // --------------------------------------------------------------------

   // one wait state: request seen, answered next cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (read | write) & ~ack_reg;
      end
   end

   assign waitrequest = (read | write) & ~ack_reg;
   assign index = word_index(address);
   assign low_lane = byteenable[0];
   // write lands at the edge where waitrequest is low
   assign wr_take = write & ack_reg;
   assign rd_take = read & ~ack_reg;

   // --------------------------------------------------------------------
   // source events into flag positions
   // --------------------------------------------------------------------

   always_comb begin
      flag_set = 8'h00;
      flag_set[BIT_TIMER] = timer_event;
      flag_set[BIT_SERIAL] = serial_event;
      flag_set[BIT_CONVERTER] = converter_event;
      flag_set[BIT_PIN1] = pin_bus.rise[1];
      flag_set[BIT_PIN0] = pin_bus.rise[0];
   end

   // --------------------------------------------------------------------
   // flag register
   // --------------------------------------------------------------------

   // sticky flags, event wins over a write
   always_comb begin
      interrupt_flags_next = interrupt_flags_reg | flag_set;
      if (wr_take && low_lane && index == IDX_FLAGS && is_mapped(index, address)) begin
         interrupt_flags_next = (writedata[7:0] & FLAGS_MASK) | flag_set;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         interrupt_flags_reg <= FLAGS_RESET;
      end else begin
         interrupt_flags_reg <= interrupt_flags_next & FLAGS_MASK;
      end
   end

   // --------------------------------------------------------------------
   // enable register
   // --------------------------------------------------------------------

   always_comb begin
      interrupt_enables_next = interrupt_enables_reg;
      if (wr_take && low_lane && index == IDX_ENABLES && is_mapped(index, address)) begin
         interrupt_enables_next = writedata[7:0] & ENABLES_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         interrupt_enables_reg <= ENABLES_RESET;
      end else begin
         interrupt_enables_reg <= interrupt_enables_next;
      end
   end

   // --------------------------------------------------------------------
   // request to the core
   // --------------------------------------------------------------------

   assign global_irq_enable = interrupt_enables_reg[BIT_GLOBAL];
   assign source_enables = interrupt_enables_reg & FLAGS_MASK;
   assign pending = interrupt_flags_reg & source_enables;

   // combine global enable and pending sources
   assign request = global_irq_enable & (|pending);

   always_ff @(posedge clk) begin
      if (rst) begin
         core_irq_reg <= 1'b0;
      end else begin
         core_irq_reg <= request;
      end
   end

   assign core_irq_request = core_irq_reg;
   assign core_irq_vector = IRQ_VECTOR;

   // --------------------------------------------------------------------
   // bus-side event status
   // --------------------------------------------------------------------

   // each flag set and each unmapped access raise a sticky bit
   always_comb begin
      evt_set = {1'b0, flag_set[4:0]};
      evt_set[EVT_BAD_ACCESS] = ((read | write) & ~ack_reg) & ~is_mapped(index, address);
   end

   // write-one-to-clear register, same layout
   always_comb begin
      evt_clear = '0;
      if (wr_take && low_lane && index == IDX_EVT_CLEAR && is_mapped(index, address)) begin
         evt_clear = writedata[EVT_W-1:0];
      end
   end

   // set wins over clear
   assign evt_status_next = (evt_status_reg & ~evt_clear) | evt_set;

   always_ff @(posedge clk) begin
      if (rst) begin
         evt_status_reg <= EVT_RESET;
      end else begin
         evt_status_reg <= evt_status_next;
      end
   end

   // event enable register
   always_ff @(posedge clk) begin
      if (rst) begin
         evt_enable_reg <= EVT_RESET;
      end else if (wr_take && low_lane && index == IDX_EVT_ENABLE && is_mapped(index, address)) begin
         evt_enable_reg <= writedata[EVT_W-1:0];
      end
   end

   // level interrupt while an enabled status bit is set
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(evt_status_next & evt_enable_reg);
      end
   end

   assign irq = irq_reg;

   // --------------------------------------------------------------------
   // read path
   // --------------------------------------------------------------------

   // read back of flags, enables, event status and event enable, unimplemented bits zero
   always_ff @(posedge clk) begin
      if (rst) begin
         readdata_reg <= 32'h0000_0000;
      end else if (rd_take) begin
         readdata_reg <= 32'h0000_0000;
         if (is_mapped(index, address)) begin
            unique case (index)
               IDX_FLAGS: readdata_reg[7:0] <= interrupt_flags_reg & FLAGS_MASK;
               IDX_ENABLES: readdata_reg[7:0] <= interrupt_enables_reg & ENABLES_MASK;
               IDX_EVT_STATUS: readdata_reg[EVT_W-1:0] <= evt_status_reg;
               IDX_EVT_ENABLE: readdata_reg[EVT_W-1:0] <= evt_enable_reg;
               default: readdata_reg <= 32'h0000_0000; // clear register reads zero
            endcase
         end
      end
   end

   assign readdata = readdata_reg;

endmodule // irq_enable_flag_unit

`default_nettype wire

/* File: tb/irq_enable_flag_unit_chk.sv */
`timescale 1ns/1ns
`default_nettype none

module irq_enable_flag_unit_chk
   import irq_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bus side
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // sources and outputs
   input wire logic timer_event,
   input wire logic serial_event,
   input wire logic converter_event,
   input wire logic port_b_line1,
   input wire logic port_b_line0,
   input wire logic core_irq_request,
   input wire logic [PC_W-1:0] core_irq_vector,
   input wire logic irq
);
   logic [7:0] en_sh;
   logic [5:0] ev_sh;
   logic done;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // a write that completes at this edge
   assign done = write && !waitrequest && byteenable[0];

   // shadows of the two enable registers
   always_ff @(posedge clk) begin
      if (rst) begin
         en_sh <= 8'h00;
         ev_sh <= 6'h00;
      end else begin
         if (done && address == 8'h1C) begin
            en_sh <= writedata[7:0] & ENABLES_MASK;
         end
         if (done && address == 8'h28) begin
            ev_sh <= writedata[5:0];
         end
      end
   end

   // --------------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------------
   a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("wait state longer than one cycle");
   a_vector_fixed: assert property (core_irq_vector == 13'h0004)
      else $error("vector address wrong");
   a_src_req: assert property ((timer_event && en_sh[4] || serial_event && en_sh[3]
      || converter_event && en_sh[2]) && en_sh[7] && !write |-> ##2 core_irq_request)
      else $error("enabled event gave no request");
   a_gie_drop: assert property (done && address == 8'h1C && !writedata[7] |-> ##2 !core_irq_request)
      else $error("request with global enable off");
   a_needs_gie: assert property (core_irq_request |-> $past(en_sh[7]))
      else $error("request without global enable");
   a_flag_sticky: assert property (core_irq_request && !$past(write) |=> core_irq_request)
      else $error("request dropped without software write");
   a_en_readback: assert property (read && !waitrequest && address == 8'h1C |-> readdata == {24'h00_0000, en_sh})
      else $error("enable readback wrong");
   a_flag_unimpl: assert property (read && !waitrequest && address == 8'h18 |-> readdata[31:5] == 27'h000_0000)
      else $error("unimplemented flag bits not zero");
   a_unmapped_zero: assert property (read && !waitrequest && (address[7:2] < 6'h06 || address[7:2] > 6'h0A)
      |-> readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_irq_mask: assert property (irq |-> ev_sh != 6'h00 || $past(ev_sh) != 6'h00)
      else $error("irq with all event enables off");
endmodule // irq_enable_flag_unit_chk

`default_nettype wire

/* File: tb/irq_src_model.sv */
`timescale 1ns/1ns
`default_nettype none

module irq_src_model (
   // clock
   input wire logic clk,
   // event sources
   output logic timer_event,
   output logic serial_event,
   output logic converter_event,
   output logic port_b_line1,
   output logic port_b_line0
);
   // idle sources
   initial begin
      {timer_event, serial_event, converter_event, port_b_line1, port_b_line0} = 5'h00;
   end

   // one-cycle pulse, or pin rise that the source drops low again nine edges later
   task fire(input int k);
      case (k)
         0: port_b_line0 <= 1'b1;
         1: port_b_line1 <= 1'b1;
         2: converter_event <= 1'b1;
         3: serial_event <= 1'b1;
         default: timer_event <= 1'b1;
      endcase
      @(posedge clk);
      {timer_event, serial_event, converter_event} <= 3'h0;
      repeat (8) @(posedge clk);
      {port_b_line1, port_b_line0} <= 2'h0;
      @(posedge clk);
   endtask
endmodule // irq_src_model

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
   import irq_pkg::*;
   logic clk, rst, read, write, waitrequest, core_irq_request, irq;
   logic timer_event, serial_event, converter_event, port_b_line1, port_b_line0;
   logic [7:0] address;
   logic [31:0] writedata, readdata;
   logic [3:0] byteenable;
   logic [PC_W-1:0] core_irq_vector;
   int err_count = 0;
   int cmp_count = 0;

   irq_enable_flag_unit #(.ADDR_W(8)) irq_enable_flag_unit_inst (.clk(clk), .rst(rst), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .timer_event(timer_event), .serial_event(serial_event),
      .converter_event(converter_event), .port_b_line1(port_b_line1), .port_b_line0(port_b_line0),
      .core_irq_request(core_irq_request), .core_irq_vector(core_irq_vector), .irq(irq));

   irq_src_model irq_src_model_inst (.clk(clk), .timer_event(timer_event), .serial_event(serial_event),
      .converter_event(converter_event), .port_b_line1(port_b_line1), .port_b_line0(port_b_line0));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // --------------------------------------------------------------------
   // tasks
   // --------------------------------------------------------------------
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask

   // one avalon transfer, held until waitrequest is sampled low at a rising edge
   task bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
      address <= a;
      writedata <= {24'h00_0000, d};
      read <= !wr;
      write <= wr;
      // waitrequest and readdata are read before the edge's own updates land
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask

   // request and irq levels, looked at mid-cycle
   task lvl(input logic er, input logic ei);
      @(negedge clk);
      chk(32'(core_irq_request), 32'(er));
      chk(32'(irq), 32'(ei));
      @(posedge clk);
   endtask

   task report_and_stop;
      if (err_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // --------------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {read, write, address, writedata, byteenable} = {2'h0, 8'h00, 32'h0000_0000, 4'hF};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(8'h18, 32'h0000_0000);
      rd(8'h1C, 32'h0000_0000);
      chk(32'(core_irq_vector), 32'h0000_0004);
      wr(8'h1C, 8'hFF);
      rd(8'h1C, 32'h0000_009F);
      wr(8'h18, 8'hFF);
      rd(8'h18, 32'h0000_001F);
      lvl(1'b1, 1'b0);
      wr(8'h18, 8'h00);
      for (int k = 0; k < 5; k++) begin
         wr(8'h1C, 8'h80);
         irq_src_model_inst.fire(k);
         rd(8'h18, 32'(1 << k));
         lvl(1'b0, 1'b0);
         wr(8'h1C, 8'h80 | 8'(1 << k));
         lvl(1'b1, 1'b0);
         wr(8'h1C, 8'(1 << k));
         lvl(1'b0, 1'b0);
         rd(8'h18, 32'(1 << k));
         wr(8'h18, 8'h00);
         rd(8'h18, 32'h0000_0000);
      end
      // event arriving while its source is already enabled
      wr(8'h1C, 8'h84);
      irq_src_model_inst.fire(2);
      lvl(1'b1, 1'b0);
      wr(8'h18, 8'h00);
      lvl(1'b0, 1'b0);
      byteenable <= 4'hE;
      wr(8'h1C, 8'h9F);
      byteenable <= 4'hF;
      rd(8'h1C, 32'h0000_0084);
      wr(8'h24, 8'h3F);
      rd(8'h20, 32'h0000_0000);
      wr(8'h28, 8'h20);
      rd(8'h3C, 32'h0000_0000);
      lvl(1'b0, 1'b1);
      rd(8'h20, 32'h0000_0020);
      wr(8'h28, 8'h00);
      lvl(1'b0, 1'b0);
      wr(8'h28, 8'h20);
      lvl(1'b0, 1'b1);
      wr(8'h24, 8'h20);
      lvl(1'b0, 1'b0);
      rd(8'h24, 32'h0000_0000);
      report_and_stop;
   end

   // hang guard, far beyond the expected run
   initial begin
      #100000;
      err_count++;
      report_and_stop;
   end
endmodule // tb_top

bind irq_enable_flag_unit irq_enable_flag_unit_chk #(.ADDR_W(ADDR_W)) chk_inst (.clk(clk), .rst(rst),
   .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
   .readdata(readdata), .waitrequest(waitrequest), .timer_event(timer_event), .serial_event(serial_event),
   .converter_event(converter_event), .port_b_line1(port_b_line1), .port_b_line0(port_b_line0),
   .core_irq_request(core_irq_request), .core_irq_vector(core_irq_vector), .irq(irq));

`default_nettype wire
